// ---- hdl/tsihp_pkg.sv ----
// package for the host-side controller of the time-slot switch microport
// assumes a 25 MHz system clock; the reset and serial clock counts derive from it
package tsihp_pkg;

  localparam int CLK_FREQ_HZ = 25000000;
  localparam int CLK_PERIOD_NS = 1000000000 / CLK_FREQ_HZ;

  // reset pulse on the device pin, least time
  localparam int RESET_LOW_NS = 100;
  localparam int RESET_LOW_CYC = (RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // strobe setup and hold around the device strobe, our own margins
  localparam int ADDR_SETUP_CYC = 2;
  localparam int STROBE_HOLD_CYC = 2;
  // bound on the wait for the acknowledge before flagging a timeout
  localparam int ACK_TIMEOUT_CYC = 255;

  // serial master clock for the device: 4.096 MHz wanted, nearest from 25 MHz
  localparam int SCLK_TARGET_HZ = 4096000;
  localparam int SCLK_HALF_CYC = (CLK_FREQ_HZ / (2 * SCLK_TARGET_HZ)) > 0 ?
                                 (CLK_FREQ_HZ / (2 * SCLK_TARGET_HZ)) : 1;

  // widths
  localparam int DATA_W = 16;
  localparam int ADDR_W = 8;

  // register offsets on the avalon slave (byte addresses)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_WDATA = 4'h8;
  localparam logic [3:0] REG_RDATA = 4'hc;
  localparam logic [3:0] REG_STATUS = 4'h0;

  // control register fields
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_READ_BIT = 1;
  localparam int CTRL_MUX_BIT = 2;
  localparam int CTRL_RWS_BIT = 3;
  localparam int CTRL_ODE_BIT = 4;
  localparam int CTRL_RST_BIT = 5;
  localparam logic [5:0] CTRL_RESET_VAL = 6'h00;

  // status register fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_TMO_BIT = 2;

  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;

endpackage

// ---- hdl/tsihp_sync2.sv ----
// two-flop synchroniser for pins that come from the device
// assumes the input is asynchronous to i_clk
`timescale 1ns/1ns
`default_nettype none
module tsihp_sync2
  import tsihp_pkg::*;
#(
  parameter int W = 1
)
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // data
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      meta_ff <= '0;
      q_ff <= '0;
    end
    else
    begin
      meta_ff <= i_d;
      q_ff <= meta_ff;
    end
  end

  assign o_q = q_ff;

endmodule
`default_nettype wire

// ---- hdl/tsihp_clkdiv.sv ----
// divider making the serial master clock for the device
// assumes one system clock; output toggles every SCLK_HALF_CYC cycles
`timescale 1ns/1ns
`default_nettype none
module tsihp_clkdiv
  import tsihp_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // divided clock
  output logic o_sclk
);

  logic [7:0] cnt_ff;
  logic sclk_ff;
  logic wrap;

  assign wrap = (cnt_ff == 8'(SCLK_HALF_CYC - 1));

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      cnt_ff <= 8'h00;
      sclk_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= wrap ? 8'h00 : cnt_ff + 8'h01;
      if (wrap)
        sclk_ff <= ~sclk_ff;
    end
  end

  assign o_sclk = sclk_ff;

endmodule
`default_nettype wire

// ---- hdl/tsihp_host.sv ----
// host controller driving the microport of a 512x512 time-slot switch
// assumes an avalon-mm master on the same clock and the device pins on the far side
//
// Overview of operation
// [RL1] device reset floats streams and port outputs
// [RL2] hold device reset low at least 100ns
// [RL3] form select high multiplexed, low separate
// [RL4] latch strobe only multiplexed, else ground
// [RL5] data strobe high muxed, low non-muxed
// [RL6] read strobe low makes device drive
// [RL7] read/write input sets data direction
// [RL8] write strobe low makes device take data
// [RL9] port answers only under chip select
// [RL10] eight address lines in non-multiplexed form
// [RL11] sixteen data bits, low byte carries address
// [RL12] device pulls acknowledge low when done
// [RL13] device drives acknowledge high, then releases
// [RL14] control output 4.096 Mb/s, 512 bits
// [RL15] drive enable low floats serial outputs
// [RL16] per-channel bit may still float output
// [RL17] frames of 32 eight-bit channels
// [RL18] input and output rates are equal
// [RL19] device detects frame pulse polarity
// [RL20] processor mode gives per-channel access
// [RL21] frame evaluation measures input offset
// [RL22] internal loopback for diagnostics
// [RL23] test reset forces tap logic reset
// [RL24] host supplies 4.096 MHz serial clock; here 25 MHz / 6, about 4.17 MHz
// [RL25] without chip select device ignores port
//
// The register addresses and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module tsihp_host
  import tsihp_pkg::*;
(
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_RST,
  // avalon-mm slave
  input wire logic [3:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  // device control pins
  output logic O_RESET_N,
  output logic O_TEST_RESET_N,
  output logic O_PORT_FORM_SELECT,
  output logic O_CS_N,
  output logic O_DATA_STROBE,
  output logic O_RW,
  output logic O_ADDRESS_LATCH_STROBE,
  output logic [ADDR_W-1:0] O_ADDR_LINES,
  output logic O_OUTPUT_DRIVE_ENABLE,
  output logic O_SERIAL_CLK,
  // two-way data pins, oe low while we drive
  input wire logic [7:0] I_ADDR_DATA_LOW,
  output logic [7:0] O_ADDR_DATA_LOW,
  output logic O_ADDR_DATA_LOW_OE_N,
  input wire logic [7:0] I_DATA_HIGH_BYTE,
  output logic [7:0] O_DATA_HIGH_BYTE,
  output logic O_DATA_HIGH_BYTE_OE_N,
  // acknowledge from the device
  input wire logic I_TRANSFER_ACK_N
);

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_RST = 7'b0000010,
    ST_ALE = 7'b0000100,
    ST_SETUP = 7'b0001000,
    ST_STROBE = 7'b0010000,
    ST_HOLD = 7'b0100000,
    ST_RECOV = 7'b1000000
  } tsihp_state_type;

  tsihp_state_type state_ff, nxt_state;

  // software registers
  logic [5:0] ctrl_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [DATA_W-1:0] wdata_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic done_ff;
  logic tmo_ff;
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;

  // pin registers
  logic reset_n_ff, trst_n_ff, cs_n_ff, ds_ff, rw_ff, ale_ff, oe_n_ff;
  logic [7:0] adl_ff;
  logic [7:0] dhb_ff;
  logic [31:0] rd_ff;
  logic wait_ff;

  logic ack_n_s;
  logic [15:0] din_s;
  logic sclk;

  // acknowledge and read data are from the device, so synchronise them
  tsihp_sync2 #(.W(1)) u_sync_ack
  (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_d(I_TRANSFER_ACK_N),
    .o_q(ack_n_s)
  );

  tsihp_sync2 #(.W(16)) u_sync_data
  (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_d({I_DATA_HIGH_BYTE, I_ADDR_DATA_LOW}),
    .o_q(din_s)
  );

  tsihp_clkdiv u_clkdiv
  (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .o_sclk(sclk)
  );

  // bus decode
  wire busy = (state_ff != ST_IDLE);
  wire muxed = ctrl_ff[CTRL_MUX_BIT];
  wire rws = ctrl_ff[CTRL_RWS_BIT] & muxed;
  wire is_read = ctrl_ff[CTRL_READ_BIT];
  wire wr_ctrl = I_AVS_WRITE & ~wait_ff & (I_AVS_ADDRESS == REG_CTRL) & I_AVS_BYTEENABLE[0];
  wire [5:0] nxt_ctrl = wr_ctrl ? {I_AVS_WRITEDATA[5:2], I_AVS_WRITEDATA[CTRL_READ_BIT], 1'b0} : ctrl_ff;
  // pins follow the form being written, so the first cycle after go is already in the new form
  wire new_mux = nxt_ctrl[CTRL_MUX_BIT];
  wire new_rws = nxt_ctrl[CTRL_RWS_BIT] & new_mux;
  wire new_rd = nxt_ctrl[CTRL_READ_BIT];
  wire wr_addr = I_AVS_WRITE & ~wait_ff & (I_AVS_ADDRESS == REG_ADDR) & I_AVS_BYTEENABLE[0];
  wire wr_wd_lo = I_AVS_WRITE & ~wait_ff & (I_AVS_ADDRESS == REG_WDATA) & I_AVS_BYTEENABLE[0];
  wire wr_wd_hi = I_AVS_WRITE & ~wait_ff & (I_AVS_ADDRESS == REG_WDATA) & I_AVS_BYTEENABLE[1];
  wire go = wr_ctrl & I_AVS_WRITEDATA[CTRL_GO_BIT] & ~busy;
  wire ack_seen = ~ack_n_s; // [RL12]
  wire tmo_hit = (cnt_ff == 8'(ACK_TIMEOUT_CYC));

  // one-cycle waitrequest: request seen with wait high, answered next edge
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
      wait_ff <= 1'b1;
    else
      wait_ff <= ~(wait_ff & (I_AVS_READ | I_AVS_WRITE));
  end

  wire [31:0] rd_mux =
    (I_AVS_ADDRESS == REG_CTRL) ? {25'h0, busy, tmo_ff, done_ff, ctrl_ff[5:2]} :
    (I_AVS_ADDRESS == REG_ADDR) ? {24'h0, addr_ff} :
    (I_AVS_ADDRESS == REG_WDATA) ? {16'h0, wdata_ff} :
    (I_AVS_ADDRESS == REG_RDATA) ? {16'h0, rdata_ff} : UNMAPPED_READ;

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
      rd_ff <= 32'h00000000;
    else if (I_AVS_READ & wait_ff)
      rd_ff <= rd_mux;
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      ctrl_ff <= CTRL_RESET_VAL;
      addr_ff <= 8'h00;
      wdata_ff <= 16'h0000;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      if (wr_addr)
        addr_ff <= I_AVS_WRITEDATA[7:0];
      if (wr_wd_lo)
        wdata_ff[7:0] <= I_AVS_WRITEDATA[7:0];
      if (wr_wd_hi)
        wdata_ff[15:8] <= I_AVS_WRITEDATA[15:8];
    end
  end

  // cycle sequencer
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff + 8'h01;
    case (state_ff)
      ST_IDLE:
      begin
        nxt_cnt = 8'h00;
        if (go & nxt_ctrl[CTRL_RST_BIT])
          nxt_state = ST_RST;
        else if (go)
          nxt_state = new_mux ? ST_ALE : ST_SETUP;
      end
      ST_RST:
        if (cnt_ff == 8'(RESET_LOW_CYC - 1)) // [RL2]
          nxt_state = ST_IDLE;
      ST_ALE:
        if (cnt_ff == 8'(ADDR_SETUP_CYC - 1))
        begin
          nxt_state = ST_SETUP;
          nxt_cnt = 8'h00;
        end
      ST_SETUP:
        if (cnt_ff == 8'(ADDR_SETUP_CYC - 1))
        begin
          nxt_state = ST_STROBE;
          nxt_cnt = 8'h00;
        end
      ST_STROBE:
        if (ack_seen | tmo_hit)
        begin
          nxt_state = ST_HOLD;
          nxt_cnt = 8'h00;
        end
      ST_HOLD:
        nxt_state = ST_RECOV;
      ST_RECOV:
        if (ack_n_s | (cnt_ff == 8'(STROBE_HOLD_CYC))) // [RL13]
          nxt_state = ST_IDLE;
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      state_ff <= ST_IDLE;
      cnt_ff <= 8'h00;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  // done and timeout flags: set wins over a clearing control write
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      done_ff <= 1'b0;
      tmo_ff <= 1'b0;
      rdata_ff <= 16'h0000;
    end
    else
    begin
      if (state_ff == ST_STROBE && (ack_seen | tmo_hit))
        done_ff <= 1'b1;
      else if (go)
        done_ff <= 1'b0;
      if (state_ff == ST_STROBE && tmo_hit && !ack_seen)
        tmo_ff <= 1'b1;
      else if (go)
        tmo_ff <= 1'b0;
      if (state_ff == ST_STROBE && ack_seen && is_read)
        rdata_ff <= din_s; // [RL11] [RL7]
    end
  end

  // pin drive
  wire in_cyc = (state_ff == ST_SETUP) | (state_ff == ST_STROBE) | (state_ff == ST_HOLD);
  wire strobe_on = (state_ff == ST_STROBE);
  wire drive_data = in_cyc & ~is_read & ~(state_ff == ST_ALE);
  // strobe polarity per form: active high muxed, active low separate and in the strobe-pair form
  wire nxt_ds = new_rws ? ~(strobe_on & new_rd) : (new_mux ? strobe_on : ~strobe_on); // [RL5] [RL6]
  // read/write line: write strobe for the strobe-pair form, level for the other
  wire nxt_rw = new_rws ? ~(strobe_on & ~new_rd) : new_rd; // [RL7] [RL8]

  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      reset_n_ff <= 1'b0;
      trst_n_ff <= 1'b0;
      cs_n_ff <= 1'b1;
      ds_ff <= 1'b1;
      rw_ff <= 1'b1;
      ale_ff <= 1'b0;
      adl_ff <= 8'h00;
      dhb_ff <= 8'h00;
      oe_n_ff <= 1'b1;
    end
    else
    begin
      reset_n_ff <= (nxt_state != ST_RST); // [RL1]
      // test port is pulsed with every device reset so it never leaves normal mode
      trst_n_ff <= (nxt_state != ST_RST); // [RL23]
      cs_n_ff <= ~((nxt_state == ST_ALE) | (nxt_state == ST_SETUP) | (nxt_state == ST_STROBE)
                   | (nxt_state == ST_HOLD)); // [RL9] [RL25]
      ds_ff <= nxt_ds;
      rw_ff <= nxt_rw;
      ale_ff <= (nxt_state == ST_ALE); // [RL4]
      adl_ff <= (nxt_state == ST_ALE) ? addr_ff : wdata_ff[7:0]; // [RL11]
      dhb_ff <= wdata_ff[15:8];
      oe_n_ff <= ~((nxt_state == ST_ALE) | drive_data);
    end
  end

  assign O_RESET_N = reset_n_ff;
  assign O_TEST_RESET_N = trst_n_ff; // [RL23]
  assign O_PORT_FORM_SELECT = ctrl_ff[CTRL_MUX_BIT]; // [RL3]
  assign O_CS_N = cs_n_ff;
  assign O_DATA_STROBE = ds_ff;
  assign O_RW = rw_ff;
  assign O_ADDRESS_LATCH_STROBE = ale_ff;
  assign O_ADDR_LINES = addr_ff; // [RL10]
  assign O_OUTPUT_DRIVE_ENABLE = ctrl_ff[CTRL_ODE_BIT]; // [RL15]
  assign O_SERIAL_CLK = sclk; // [RL24]
  assign O_ADDR_DATA_LOW = adl_ff;
  assign O_ADDR_DATA_LOW_OE_N = oe_n_ff;
  assign O_DATA_HIGH_BYTE = dhb_ff;
  assign O_DATA_HIGH_BYTE_OE_N = oe_n_ff;
  assign O_AVS_READDATA = rd_ff;
  assign O_AVS_WAITREQUEST = wait_ff;

  // reset pulse on the device pin lasts the documented least time
  sequence s_rst_low;
    !O_RESET_N [*3];
  endsequence

  a_reset_pulse_len: assert property (@(posedge I_CLK) disable iff (I_RST) // [RL2]
    $fell(O_RESET_N) |-> s_rst_low)
    else $error("device reset pulse too short");

  a_strobe_needs_cs: assert property (@(posedge I_CLK) disable iff (I_RST) // [RL9]
    (state_ff == ST_STROBE) |-> !cs_n_ff)
    else $error("strobe without chip select");

  a_ale_only_muxed: assert property (@(posedge I_CLK) disable iff (I_RST) // [RL4]
    !O_PORT_FORM_SELECT |-> !O_ADDRESS_LATCH_STROBE)
    else $error("latch strobe in non-multiplexed form");

  a_read_no_drive: assert property (@(posedge I_CLK) disable iff (I_RST) // [RL7]
    ($past(state_ff) == ST_STROBE && is_read) |-> O_ADDR_DATA_LOW_OE_N)
    else $error("host drives data during read");

  a_idle_cs_high: assert property (@(posedge I_CLK) disable iff (I_RST) // [RL25]
    ($past(state_ff) == ST_IDLE && state_ff == ST_IDLE) |-> O_CS_N)
    else $error("chip select asserted while idle");

  a_ack_done: assert property (@(posedge I_CLK) disable iff (I_RST) // [RL12]
    (state_ff == ST_STROBE && ack_seen) |=> done_ff)
    else $error("acknowledge not recorded");

  a_ds_polarity: assert property (@(posedge I_CLK) disable iff (I_RST) // [RL5]
    (!rws && $past(state_ff) == ST_STROBE && state_ff != ST_IDLE) |-> (O_DATA_STROBE == muxed))
    else $error("data strobe polarity wrong");

  a_ode_follows: assert property (@(posedge I_CLK) disable iff (I_RST) // [RL15]
    $past(wr_ctrl) |-> (O_OUTPUT_DRIVE_ENABLE == $past(I_AVS_WRITEDATA[CTRL_ODE_BIT])))
    else $error("drive enable mismatch");

endmodule
`default_nettype wire

// ---- sim/tsihp_dev.sv ----
// behavioural model of the switch microport and its reset pin
// assumes the bench resolves the two-way data pins and the acknowledge pull-up
`timescale 1ns/1ns
`default_nettype none
module tsihp_dev
  import tsihp_pkg::*;
(
  // clock and bench controls
  input wire logic i_clk,
  input wire logic i_rws,
  input wire logic [3:0] i_lat,
  input wire logic i_noack,
  // device pins
  input wire logic i_reset_n,
  input wire logic i_form,
  input wire logic i_cs_n,
  input wire logic i_ds,
  input wire logic i_rw,
  input wire logic i_ale,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_dq,
  input wire logic i_host_oe_n,
  // answers
  output logic [15:0] o_dq,
  output logic o_ack_n,
  output int o_viol
);
  logic [15:0] mem [256];
  logic [7:0] lat_a;
  logic [3:0] cnt;
  logic [15:0] last;
  int rst_cnt;
  wire act = !i_cs_n && i_reset_n && (i_rws ? !(i_ds && i_rw) : i_ds == i_form);
  wire rd = i_rws ? !i_ds : i_rw;
  wire [7:0] a = i_form ? lat_a : i_addr;
  wire drv = act && rd;
  wire done = act && cnt >= i_lat && !i_noack;
  // released pins show the inverse of the last level so stale data cannot pass
  assign o_dq = drv ? mem[a] : ~last;
  // driven high and released look alike behind the pull-up
  assign o_ack_n = !done;
  always_ff @(posedge i_clk)
  begin
    last <= i_dq;
    if (i_ale)
      lat_a <= i_dq[7:0];
    cnt <= act ? (cnt == 4'hf ? cnt : cnt + 4'h1) : 4'h0;
    if (done && !rd && cnt == i_lat)
      mem[a] <= i_dq;
    rst_cnt <= i_reset_n ? 0 : rst_cnt + 1;
    if (!i_reset_n)
      foreach (mem[k]) mem[k] <= 16'h0;
    o_viol <= o_viol + int'(i_reset_n && rst_cnt > 0 && rst_cnt < RESET_LOW_CYC)
      + int'(i_ale && !i_form) + int'(drv && !i_host_oe_n);
  end
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
// self-checking bench for the microport host controller
// assumes the device model runs on the controller clock
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb;
  import tsihp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0;
  logic rws = 1'b0;
  logic noack = 1'b0;
  logic [3:0] lat = 4'h0;
  logic sclk_q = 1'b0;
  int half = -1;
  int errors = 0;
  int compares = 0;
  int viol;
  logic [15:0] refm [256];
  wire [31:0] rdata;
  wire wreq, reset_n, trst_n, form, cs_n, ds, rw, ale, output_drive_enable, sclk, loe_n, hoe_n, ack_n;
  wire [7:0] al, dlo, dhi;
  wire [15:0] dev_dq;
  wire [15:0] dq = {hoe_n ? dev_dq[15:8] : dhi, loe_n ? dev_dq[7:0] : dlo};
  tsihp_host tsihp_host_inst (.I_CLK(clk), .I_RST(rst), .I_AVS_ADDRESS(adr), .I_AVS_READ(rd), .I_AVS_WRITE(wr),
    .I_AVS_WRITEDATA(wd), .I_AVS_BYTEENABLE(4'hf), .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(wreq),
    .O_RESET_N(reset_n), .O_TEST_RESET_N(trst_n), .O_PORT_FORM_SELECT(form), .O_CS_N(cs_n), .O_DATA_STROBE(ds),
    .O_RW(rw), .O_ADDRESS_LATCH_STROBE(ale), .O_ADDR_LINES(al), .O_OUTPUT_DRIVE_ENABLE(output_drive_enable), .O_SERIAL_CLK(sclk),
    .I_ADDR_DATA_LOW(dq[7:0]), .O_ADDR_DATA_LOW(dlo), .O_ADDR_DATA_LOW_OE_N(loe_n), .I_DATA_HIGH_BYTE(dq[15:8]),
    .O_DATA_HIGH_BYTE(dhi), .O_DATA_HIGH_BYTE_OE_N(hoe_n), .I_TRANSFER_ACK_N(ack_n));
  tsihp_dev tsihp_dev_inst (.i_clk(clk), .i_rws(rws), .i_lat(lat), .i_noack(noack), .i_reset_n(reset_n),
    .i_form(form), .i_cs_n(cs_n), .i_ds(ds), .i_rw(rw), .i_ale(ale), .i_addr(al), .i_dq(dq),
    .i_host_oe_n(loe_n & hoe_n), .o_dq(dev_dq), .o_ack_n(ack_n), .o_viol(viol));
  task automatic report_and_stop();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic hang();
    errors++;
    $display("[ERR] %0t wait ran out", $time);
    report_and_stop();
  endtask
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (wreq === 1'b0)
        break;
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n == 50)
      hang();
  endtask
  // m holds the ctrl bits {ode, strobe pair, multiplexed, read}
  task automatic xfer(input logic [3:0] m, input logic [7:0] a, input logic [15:0] d,
    output logic [31:0] st, output logic [31:0] q);
    int n;
    av(1'b1, REG_ADDR, {24'h0, a}, q);
    av(1'b1, REG_WDATA, {16'h0, d}, q);
    av(1'b1, REG_CTRL, {27'h0, m, 1'b1}, q);
    for (n = 0; n < 200; n++)
    begin
      av(1'b0, REG_STATUS, 32'h0, st);
      if ((st[4] === 1'b1 || st[5] === 1'b1) && st[6] === 1'b0)
        break;
    end
    if (n == 200)
      hang();
    av(1'b0, REG_RDATA, 32'h0, q);
  endtask
  initial
  begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    sclk_q <= sclk;
    if (rst || sclk === sclk_q)
      half = half < 0 ? half : half + 1;
    else
    begin
      if (half > 0)
        `CHK(half, SCLK_HALF_CYC)
      half = 1;
    end
  end
  initial
  begin
    repeat (90000) @(posedge clk);
    hang();
  end
  initial
  begin
    logic [31:0] st, q;
    logic [3:0] m;
    logic [7:0] a;
    logic [15:0] d;
    void'($urandom(63870));
    foreach (refm[k]) refm[k] = 16'h0;
    repeat (2) @(posedge clk);
    #1 `CHK({wreq, cs_n, loe_n, hoe_n, reset_n, trst_n}, 6'b111100)
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    av(1'b0, REG_STATUS, 32'h0, q);
    `CHK(q[6:0], 7'h00)
    av(1'b0, 4'h2, 32'h0, q);
    `CHK(q, UNMAPPED_READ)
    av(1'b1, 4'h6, 32'hffffffff, q);
    for (int i = 0; i < 24; i++)
    begin
      m = 4'($urandom);
      // the strobe pair exists only in multiplexed form
      m[2] = m[2] & m[1];
      m[0] = i[0];
      if (!m[0])
        a = i == 0 ? 8'hff : 8'($urandom);
      d = i == 0 ? 16'hffff : 16'($urandom);
      lat <= 4'($urandom_range(0, 6));
      rws <= m[2];
      xfer(m, a, d, st, q);
      `CHK(st[6:0], {3'b001, 1'b0, m[3:1]})
      `CHK({form, output_drive_enable}, {m[1], m[3]})
      if (m[0])
        `CHK(q[15:0], refm[a])
      else
        refm[a] = d;
    end
    noack <= 1'b1;
    rws <= 1'b0;
    xfer(4'h0, 8'h11, 16'h1234, st, q);
    `CHK(st[6:5], 2'b01)
    noack <= 1'b0;
    av(1'b1, REG_CTRL, 32'h21, q);
    for (int n = 0; n < 20 && reset_n !== 1'b0; n++)
      @(posedge clk);
    `CHK({reset_n, trst_n}, 2'b00)
    for (int n = 0; n < 20 && reset_n !== 1'b1; n++)
      @(posedge clk);
    av(1'b1, REG_CTRL, 32'h0, q);
    xfer(4'h1, a, 16'h0, st, q);
    `CHK(q[15:0], 16'h0)
    `CHK(viol, 0)
    `CHK(trst_n, 1'b1)
    report_and_stop();
  end
endmodule
`default_nettype wire
